// ### logic/ufc_defs.vh
// register map, field positions and reset values of the fifo control block
`ifndef UFC_DEFS_VH
`define UFC_DEFS_VH
// byte offsets on the apb bus
`define UFC_OFF_DATA   8'h00
`define UFC_OFF_IEN    8'h04
`define UFC_OFF_FCIID  8'h08
`define UFC_OFF_LSR    8'h0C
`define UFC_OFF_HSR    8'h10
`define UFC_OFF_STAT   8'h14
// fifo_control fields
`define UFC_FC_EN      0
`define UFC_FC_RXRST   1
`define UFC_FC_TXRST   2
`define UFC_FC_DMA     3
`define UFC_FC_TRIG_HI 7
`define UFC_FC_TRIG_LO 6
// interrupt enable fields
`define UFC_IE_RDA     0
`define UFC_IE_THRE    1
`define UFC_IE_LSR     2
`define UFC_IE_HSR     3
// interrupt identification codes, bits 3:0
`define UFC_ID_NONE    4'h1
`define UFC_ID_LSR     4'h6
`define UFC_ID_RDA     4'h4
`define UFC_ID_TMO     4'hC
`define UFC_ID_THRE    4'h2
`define UFC_ID_HSR     4'h0
// receive trigger levels in bytes
`define UFC_TRIG_0     6'h01
`define UFC_TRIG_1     6'h04
`define UFC_TRIG_2     6'h08
`define UFC_TRIG_3     6'h0E
// character times before a receive timeout
`define UFC_TMO_CHARS  3'h4
// reset values
`define UFC_RST_FC     8'h00
`define UFC_RST_IEN    4'h0
`define UFC_RST_IID    8'h01
`endif

// ### logic/ufc_top.v
// fifo control, interrupt identification and data fifos of a serial port
// Contract
// - bits 7:6 pick trigger 1/4/8/14 bytes
// - bit 3 selects dma mode 1 in fifo mode
// - bit 2 resets transmit fifo, self-clearing
// - bit 1 resets receive fifo, self-clearing
// - bit 0 switches fifo mode on/off
// - id bits 7:6 mirror fifo enable
// - id bit 0 low when interrupt pending
// - id bit 3 timeout only in fifo mode
// - id bits 2:1 give top priority source
// - line errors first, cleared by status read
// - data ready second, cleared below trigger
// - timeout after four idle character times
// - transmit empty third, cleared by write/id read
// - each class gated by own enable
// - record cts/dsr/dcd toggles, ring trailing edge
`include "ufc_defs.vh"
`default_nettype none

module ufc_top #(
  parameter DEPTH = 32, // words in each data fifo
  parameter AW    = 5   // log2 of depth
) (
  input  wire        clock,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // received characters from the deserializer
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_parity_err,
  input  wire        rx_frame_err,
  input  wire        rx_break,
  output reg         rx_ready,
  // characters toward the serializer
  output wire        tx_valid,
  output wire [7:0]  tx_data,
  input  wire        tx_ready,
  // one pulse per character time from the baud logic
  input  wire        char_tick,
  // handshake pins, active low, asynchronous
  input  wire        cts_n,
  input  wire        dsr_n,
  input  wire        ri_n,
  input  wire        dcd_n,
  // outputs
  output reg         irq,
  output reg         rx_dma_req,
  output reg         tx_dma_req
);

  // trigger level from the two control bits
  function [5:0] trig_level;
    input [1:0] code;
    begin
      case (code)
        2'b00:   trig_level = `UFC_TRIG_0;
        2'b01:   trig_level = `UFC_TRIG_1;
        2'b10:   trig_level = `UFC_TRIG_2;
        default: trig_level = `UFC_TRIG_3;
      endcase
    end
  endfunction

  // control state
  reg        fifo_en;   // fifo mode
  reg        dma_mode;  // dma mode select bit as written
  reg  [1:0] trig_sel;  // receive trigger code
  reg  [3:0] int_en;    // interrupt class enables
  reg        rx_clr;    // one-cycle receive fifo reset
  reg        tx_clr;    // one-cycle transmit fifo reset
  // sticky flags
  reg        overrun_flag;
  reg        parity_error_flag;
  reg        framing_error_flag;
  reg        break_detect_flag;
  reg        cts_change_flag;
  reg        dsr_change_flag;
  reg        ring_edge_flag;
  reg        dcd_change_flag;
  reg        thre_pend;  // transmit empty pending
  reg        tx_empty_d; // last transmit empty, for edge
  reg        thre_en_d;  // last transmit interrupt enable
  reg  [2:0] to_cnt;     // character times since last access
  // handshake synchronisers
  reg  [3:0] hs_meta;    // first stage, read by hs_sync only
  reg  [3:0] hs_sync;
  reg  [3:0] hs_last;

  // apb decode
  wire       acc     = psel & penable & pready;
  wire       wr      = acc & pwrite;
  wire       rd      = acc & ~pwrite;
  wire       a_data  = (paddr == `UFC_OFF_DATA);
  wire       a_fc    = (paddr == `UFC_OFF_FCIID);
  wire       a_lsr   = (paddr == `UFC_OFF_LSR);
  wire       a_hsr   = (paddr == `UFC_OFF_HSR);
  wire       a_ien   = (paddr == `UFC_OFF_IEN);
  wire       a_stat  = (paddr == `UFC_OFF_STAT);
  wire       mapped  = a_data | a_fc | a_lsr | a_hsr | a_ien | a_stat;

  // fifo handshakes
  wire [7:0]  rx_q;
  wire        rx_out_valid;
  wire        rx_in_ready;
  wire [AW:0] rx_count;
  wire        tx_in_ready;
  wire [AW:0] tx_count;
  wire        rx_pop  = rd & a_data & rx_out_valid;
  wire        tx_push = wr & a_data;
  // without fifo mode each direction holds a single character
  wire        rx_room = fifo_en ? rx_in_ready : (rx_count == {(AW+1){1'b0}});
  wire        tx_room = fifo_en ? tx_in_ready : (tx_count == {(AW+1){1'b0}});
  wire        rx_push = rx_valid & rx_room;
  wire        tx_empty = (tx_count == {(AW+1){1'b0}});

  // receive fifo; a control write reset or mode change empties it
  ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
    .clock     (clock),
    .rst       (rst),
    .clear     (rx_clr),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (rx_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_q),
    .count     (rx_count)
  );

  // transmit fifo; the serializer drains it and may stall
  ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
    .clock     (clock),
    .rst       (rst),
    .clear     (tx_clr),
    .in_valid  (tx_push & tx_room),
    .in_ready  (tx_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data),
    .count     (tx_count)
  );

  // interrupt sources, each gated by its class enable
  wire lsr_any  = overrun_flag | parity_error_flag | framing_error_flag | break_detect_flag;
  wire hsr_any  = cts_change_flag | dsr_change_flag | ring_edge_flag | dcd_change_flag;
  wire at_trig  = fifo_en ? (rx_count >= trig_level(trig_sel))
                          : rx_out_valid;
  wire timeout  = fifo_en & (to_cnt == `UFC_TMO_CHARS) & rx_out_valid;
  wire src_lsr  = int_en[`UFC_IE_LSR] & lsr_any;
  wire src_rda  = int_en[`UFC_IE_RDA] & at_trig;
  wire src_tmo  = int_en[`UFC_IE_RDA] & timeout;
  wire src_thre = int_en[`UFC_IE_THRE] & thre_pend;
  wire src_hsr  = int_en[`UFC_IE_HSR] & hsr_any;

  // priority encode, only one source shows at a time
  reg [3:0] id_code;
  always @* begin
    if (src_lsr)
      id_code = `UFC_ID_LSR;
    else if (src_rda)
      id_code = `UFC_ID_RDA;
    else if (src_tmo)
      id_code = `UFC_ID_TMO;
    else if (src_thre)
      id_code = `UFC_ID_THRE;
    else if (src_hsr)
      id_code = `UFC_ID_HSR;
    else
      id_code = `UFC_ID_NONE;
  end
  // fifo bits on top, reserved bits zero
  wire [7:0] id_reg = {{2{fifo_en}}, 2'b00, id_code};

  // read data mux, answered one cycle ahead of the access edge
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0000_0000;
    if (a_data)
      next_prdata = {24'h00_0000, rx_q};
    else if (a_ien)
      next_prdata = {28'h000_0000, int_en};
    else if (a_fc)
      next_prdata = {24'h00_0000, id_reg}; // fifo_control itself is write only
    else if (a_lsr)
      next_prdata = {26'h000_0000, tx_empty, break_detect_flag, framing_error_flag,
                     parity_error_flag, overrun_flag, rx_out_valid};
    else if (a_hsr)
      next_prdata = {24'h00_0000, ~hs_sync[3], ~hs_sync[2], ~hs_sync[1], ~hs_sync[0],
                     dcd_change_flag, ring_edge_flag, dsr_change_flag, cts_change_flag};
    else if (a_stat)
      next_prdata = {10'h000, tx_count, 2'b00, rx_count, 7'h00, dma_mode & fifo_en};
  end

  // apb slave: no wait state, pready rises in the first access cycle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        pslverr <= ~mapped; // unmapped address answers with an error
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  // control register writes; the reset bits are never stored
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      fifo_en  <= 1'b0;
      dma_mode <= 1'b0;
      trig_sel <= 2'b00;
      int_en   <= `UFC_RST_IEN;
      rx_clr   <= 1'b0;
      tx_clr   <= 1'b0;
    end else begin
      rx_clr <= 1'b0;
      tx_clr <= 1'b0;
      if (wr & a_ien)
        int_en <= pwdata[3:0];
      if (wr & a_fc) begin
        fifo_en  <= pwdata[`UFC_FC_EN];
        dma_mode <= pwdata[`UFC_FC_DMA];
        trig_sel <= pwdata[`UFC_FC_TRIG_HI:`UFC_FC_TRIG_LO];
        // a mode change also flushes both fifos so stale data cannot linger
        rx_clr   <= pwdata[`UFC_FC_RXRST] | (pwdata[`UFC_FC_EN] ^ fifo_en);
        tx_clr   <= pwdata[`UFC_FC_TXRST] | (pwdata[`UFC_FC_EN] ^ fifo_en);
      end
    end
  end

  // line error flags; a new error in the clearing cycle is kept
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      overrun_flag       <= 1'b0;
      parity_error_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
      break_detect_flag  <= 1'b0;
    end else begin
      overrun_flag       <= (rx_valid & ~rx_room) | (overrun_flag & ~(rd & a_lsr));
      parity_error_flag  <= (rx_push & rx_parity_err) | (parity_error_flag & ~(rd & a_lsr));
      framing_error_flag <= (rx_push & rx_frame_err) | (framing_error_flag & ~(rd & a_lsr));
      break_detect_flag  <= (rx_push & rx_break) | (break_detect_flag & ~(rd & a_lsr));
    end
  end

  // handshake pins: two-stage synchroniser then edge detect
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_meta <= 4'hF;
      hs_sync <= 4'hF;
      hs_last <= 4'hF;
    end else begin
      hs_meta <= {dcd_n, ri_n, dsr_n, cts_n};
      hs_sync <= hs_meta;
      hs_last <= hs_sync;
    end
  end

  // handshake change flags, set wins over the clearing read
  wire [3:0] hs_diff = hs_sync ^ hs_last;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cts_change_flag <= 1'b0;
      dsr_change_flag <= 1'b0;
      ring_edge_flag  <= 1'b0;
      dcd_change_flag <= 1'b0;
    end else begin
      cts_change_flag <= hs_diff[0] | (cts_change_flag & ~(rd & a_hsr));
      dsr_change_flag <= hs_diff[1] | (dsr_change_flag & ~(rd & a_hsr));
      // ring flags only the pin going low to high, the end of a ring
      ring_edge_flag  <= (hs_sync[2] & ~hs_last[2]) | (ring_edge_flag & ~(rd & a_hsr));
      dcd_change_flag <= hs_diff[3] | (dcd_change_flag & ~(rd & a_hsr));
    end
  end

  // transmit empty: armed when the fifo drains or the enable rises
  wire thre_set = (tx_empty & ~tx_empty_d) | (int_en[`UFC_IE_THRE] & ~thre_en_d & tx_empty);
  wire thre_clr = tx_push | (rd & a_fc & (id_code == `UFC_ID_THRE));
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      thre_pend  <= 1'b0;
      tx_empty_d <= 1'b1;
      thre_en_d  <= 1'b0;
    end else begin
      tx_empty_d <= tx_empty;
      thre_en_d  <= int_en[`UFC_IE_THRE];
      thre_pend  <= thre_set | (thre_pend & ~thre_clr);
    end
  end

  // timeout counter in character times; a receive push or pop restarts it
  always @(posedge clock or posedge rst) begin
    if (rst)
      to_cnt <= 3'h0;
    else if (rx_push | rx_pop | rx_clr | ~rx_out_valid | ~fifo_en)
      to_cnt <= 3'h0;
    else if (char_tick & (to_cnt != `UFC_TMO_CHARS))
      to_cnt <= to_cnt + 3'h1;
  end

  // registered outputs: irq, dma requests, receive ready
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irq        <= 1'b0;
      rx_dma_req <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_ready   <= 1'b0;
    end else begin
      irq      <= ~id_code[0];
      rx_ready <= rx_room;
      if (fifo_en & dma_mode) begin
        rx_dma_req <= at_trig | timeout;
        tx_dma_req <= tx_in_ready;
      end else begin
        rx_dma_req <= rx_out_valid;
        tx_dma_req <= tx_empty;
      end
    end
  end

endmodule

// synchronous fifo with width and depth parameters
module ufc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             clear,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output reg  [AW:0]      count
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  wire push = in_valid & in_ready;
  wire pop  = out_ready & out_valid;

  // storage has no reset, only the pointers and count do
  always @(posedge clock) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and count; clear returns them to the start
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (clear) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        count <= count + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        count <= count - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// ### sim/ufc_top_asserts.sv
// port-level checker for the fifo control block
`include "ufc_defs.vh"
`default_nettype none
module ufc_top_asserts (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        rx_ready,
  input wire logic        tx_valid,
  input wire logic        cts_n,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       fen;                         // shadow of fifo enable
  logic [3:0] ien;                         // shadow of interrupt enables
  wire logic  done = psel & penable & pready;
  // shadows follow completed writes only, as the device does
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      fen <= 1'b0;
      ien <= 4'h0;
    end else if (done && pwrite && paddr == `UFC_OFF_FCIID) begin
      fen <= pwdata[0];
    end else if (done && pwrite && paddr == `UFC_OFF_IEN) begin
      ien <= pwdata[3:0];
    end
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_id_read;
    done && !pwrite && paddr == `UFC_OFF_FCIID;
  endsequence
  sequence s_fc_write;
    psel && !penable && pwrite && paddr == `UFC_OFF_FCIID ##1 done;
  endsequence
  AST_IRQ_GATED: assert property ((ien == 4'h0)[*3] |-> !irq)
    else $error("irq with every class disabled");
  AST_ID_FIFO_BITS: assert property (s_id_read |-> prdata[7:6] == {2{fen}})
    else $error("id bits 7:6 differ from fifo enable");
  AST_ID_RSVD: assert property (s_id_read |-> prdata[5:4] == 2'h0)
    else $error("id reserved bits set");
  AST_ID_BIT3: assert property (s_id_read ##0 !fen |-> !prdata[3])
    else $error("timeout bit outside fifo mode");
  AST_ID_CODES: assert property (s_id_read |-> prdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2, 4'h0})
    else $error("id code not a single source");
  AST_ID_NONE: assert property ((ien == 4'h0)[*4] ##0 s_id_read |-> prdata[3:0] == 4'h1)
    else $error("pending shown with enables off");
  AST_TX_FLUSH: assert property (s_fc_write ##0 pwdata[2] |-> ##2 !tx_valid)
    else $error("tx fifo not flushed");
  AST_RX_FLUSH: assert property (s_fc_write ##0 pwdata[1] |-> ##[1:3] rx_ready)
    else $error("rx fifo has no room after flush");
  AST_HS_IRQ: assert property (ien == 4'h8 && $changed(cts_n) |-> ##[1:6] irq)
    else $error("handshake change raised no irq");
endmodule
bind ufc_top ufc_top_asserts i_ufc_top_asserts (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .cts_n(cts_n), .irq(irq));
`default_nettype wire

// ### sim/ufc_serial_model.sv
// serializer and deserializer stand-in at the far side of the data fifos
`default_nettype none
module ufc_serial_model (
  input  wire logic      clock,
  input  wire logic      rst,
  output var  logic      rx_valid,
  output var  logic [7:0] rx_data,
  output var  logic [2:0] rx_err,   // break, framing, parity
  input  wire logic      rx_ready,
  input  wire logic      tx_valid,
  input  wire logic [7:0] tx_data,
  output var  logic      tx_ready,
  input  wire logic      tx_hold   // stall the transmit side
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];               // bytes taken from the tx fifo
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_err   = 3'h0;
  end
  // offer one byte for one cycle once room is shown
  task send(input logic [7:0] b, input logic [2:0] e);
    do @(negedge clock); while (rx_ready !== 1'b1);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data  <= b;
    rx_err   <= e;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data  <= ~b;                 // released lines never keep the byte
    rx_err   <= ~e;
  endtask
  // drain side, ready lags the stall request by one cycle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= !tx_hold;
      if (tx_valid && tx_ready) got.push_back(tx_data);
    end
  end
endmodule
`default_nettype wire

// ### sim/ufc_top_tb.sv
// self-checking bench for the fifo control and interrupt id block
`include "ufc_defs.vh"
`default_nettype none
module ufc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, psel, penable, pwrite, char_tick, tx_hold, f, err;
  logic [3:0]  hs_n;                // dcd, ri, dsr, cts pins
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, rd;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, irq, rx_dma_req, tx_dma_req;
  wire logic [7:0] rx_data, tx_data;
  wire logic [2:0] rx_err;
  int          n_errors, check_count, seed;
  int          lv[4] = '{`UFC_TRIG_0, `UFC_TRIG_1, `UFC_TRIG_2, `UFC_TRIG_3};
  logic [7:0]  rxq[$], txq[$];      // reference contents of both fifos
  ufc_top i_ufc_top (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_parity_err(rx_err[0]), .rx_frame_err(rx_err[1]),
    .rx_break(rx_err[2]), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .char_tick(char_tick), .cts_n(hs_n[0]), .dsr_n(hs_n[1]), .ri_n(hs_n[2]),
    .dcd_n(hs_n[3]), .irq(irq), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));
  ufc_serial_model i_ufc_serial_model (.clock(clock), .rst(rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_err(rx_err), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_hold(tx_hold));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    repeat (2) @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // pready is sampled at the rising edge that completes the access
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task push(input int n, input logic [2:0] e);
    repeat (n) begin
      b = $random(seed);
      rxq.push_back(b);
      i_ufc_serial_model.send(b, e);
    end
  endtask
  // pop one byte through the data register and compare with the reference
  task pop;
    apb(1'b0, `UFC_OFF_DATA, 32'h0000_0000);
    chk(rd[7:0], rxq.pop_front());
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(posedge clock);
      char_tick <= 1'b1;
      @(posedge clock);
      char_tick <= 1'b0;
    end
  endtask
  task wrap_up;
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    wrap_up();
  end
  initial begin
    {rst, psel, penable, pwrite, char_tick, tx_hold} = 6'h21;
    {paddr, pwdata, hs_n} = 44'h0_0000_0000_F;
    seed = 32'h7f89f97a;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rdc(`UFC_OFF_FCIID, 8'h01);
    rdc(8'h18, 8'h00);
    chk(err, 1'b1);
    wr(`UFC_OFF_FCIID, 8'h01);
    rdc(`UFC_OFF_FCIID, 8'hC1);
    wr(`UFC_OFF_IEN, 8'h01);
    // every trigger code: one byte short, at level, then back below
    for (int t = 0; t < 4; t++) begin
      wr(`UFC_OFF_FCIID, {t[1:0], 6'h03});
      rxq.delete();
      push(lv[t] - 1, 3'h0);
      rdc(`UFC_OFF_FCIID, 8'hC1);
      push(1, 3'h0);
      rdc(`UFC_OFF_FCIID, 8'hC4);
      pop();
      rdc(`UFC_OFF_FCIID, 8'hC1);
    end
    wr(`UFC_OFF_FCIID, 8'hC3);
    rxq.delete();
    push(1, 3'h0);
    rdc(`UFC_OFF_STAT, 32'h0000_0100);
    ticks(3);
    push(1, 3'h0);
    ticks(3);
    rdc(`UFC_OFF_FCIID, 8'hC1);
    ticks(1);
    rdc(`UFC_OFF_FCIID, 8'hCC);
    pop();
    rdc(`UFC_OFF_FCIID, 8'hC1);
    chk(rx_dma_req, 1'b1);
    chk(tx_dma_req, 1'b1);
    wr(`UFC_OFF_FCIID, 8'hC9);
    // the request outputs are registered one cycle behind the mode bit
    repeat (2) @(negedge clock);
    chk(rx_dma_req, 1'b0);
    chk(tx_dma_req, 1'b1);
    rdc(`UFC_OFF_STAT, 32'h0000_0101);
    wr(`UFC_OFF_FCIID, 8'h00);
    rxq.delete();
    push(1, 3'h0);
    ticks(6);
    rdc(`UFC_OFF_FCIID, 8'h04);
    pop();
    rdc(`UFC_OFF_FCIID, 8'h01);
    wr(`UFC_OFF_FCIID, 8'h01);
    wr(`UFC_OFF_IEN, 8'h05);
    // parity, framing and break each outrank data ready
    for (int e = 0; e < 3; e++) begin
      push(1, 3'(1 << e));
      rdc(`UFC_OFF_FCIID, 8'hC6);
      rdc(`UFC_OFF_LSR, 8'h21 | (8'h04 << e));
      rdc(`UFC_OFF_FCIID, 8'hC4);
      pop();
    end
    tx_hold <= 1'b1;
    wr(`UFC_OFF_IEN, 8'h02);
    rdc(`UFC_OFF_FCIID, 8'hC2);
    for (int i = 0; i < 33; i++) begin
      b = $random(seed);
      if (i < 32) txq.push_back(b);
      wr(`UFC_OFF_DATA, b);
      if (i == 0) rdc(`UFC_OFF_FCIID, 8'hC1);
    end
    rdc(`UFC_OFF_STAT, 32'h0020_0000);
    chk(tx_dma_req, 1'b0);
    tx_hold <= 1'b0;
    repeat (100) @(posedge clock);
    chk(i_ufc_serial_model.got.size(), 32);
    foreach (txq[i]) chk(i_ufc_serial_model.got[i], txq[i]);
    rdc(`UFC_OFF_FCIID, 8'hC2);
    rdc(`UFC_OFF_FCIID, 8'hC1);
    tx_hold <= 1'b1;
    wr(`UFC_OFF_DATA, 8'h5A);
    wr(`UFC_OFF_FCIID, 8'h05);
    rdc(`UFC_OFF_STAT, 32'h0000_0000);
    tx_hold <= 1'b0;
    wr(`UFC_OFF_IEN, 8'h08);
    // lower then raise each pin; ring counts only its trailing edge
    for (int k = 0; k < 8; k++) begin
      hs_n[k % 4] <= (k > 3);
      f = (k % 4 != 2) || (k > 3);
      repeat (6) @(posedge clock);
      rdc(`UFC_OFF_FCIID, f ? 8'hC0 : 8'hC1);
      chk(irq, f);
      rdc(`UFC_OFF_HSR, {~hs_n, 4'h0} | (8'(f) << (k % 4)));
    end
    wr(`UFC_OFF_IEN, 8'h00);
    rdc(`UFC_OFF_FCIID, 8'hC1);
    wrap_up();
  end
endmodule
`default_nettype wire
